// file: rtl/abu_pkg.sv
// Package: register map, field positions, vectors and reset values
package abu_pkg;

    // ************************************************************
    // Register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFF_ADDRESS_HIGH   = 8'h04;
    localparam logic [7:0] OFF_ADDRESS_LOW    = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS     = 8'h0C;
    localparam logic [7:0] OFF_IRQ_ENABLE     = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLEAR      = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int IRQ_MATCH  = 0;
    localparam int IRQ_SOFT   = 1;
    localparam int IRQ_END    = 2;
    localparam int IRQ_W      = 3;

    // ************************************************************
    // Reset values and vectors
    // ************************************************************
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [15:0] VEC_USER        = 16'hFFFC;
    localparam logic [15:0] VEC_MONITOR     = 16'hFEFC;
    localparam logic [7:0]  SOFT_INT_OPCODE = 8'h83;

endpackage : abu_pkg

// file: rtl/abu_top.sv
// Address breakpoint unit with APB register slave
`timescale 1ns/1ps
`default_nettype none

module abu_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] cpu_address,
    input  wire logic        cpu_address_valid,
    input  wire logic        cpu_last_cycle,
    input  wire logic        cpu_return_from_interrupt,
    input  wire logic        monitor_mode,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        test_high_voltage_pin,
    output logic             break_request,
    output logic             break_state,
    output logic [15:0]      break_vector,
    output logic [7:0]       software_interrupt_opcode,
    output logic             timer_halt,
    output logic             watchdog_disable,
    output logic             irq
);

    // ************************************************************
    // Registers and state
    // ************************************************************
    logic        break_enable_bit;
    logic        break_active_flag;
    logic [7:0]  break_address_high;
    logic [7:0]  break_address_low;
    logic [2:0]  irq_status;
    logic [2:0]  irq_enable;
    logic        pending;
    logic [2:0]  hv_sync;
    logic        hv_level;

    typedef enum logic [1:0] {
        ABU_IDLE  = 2'b01,
        ABU_BREAK = 2'b10
    } abu_state_t;
    abu_state_t state;

    // Bus strobes and break conditions
    logic wr_access;
    logic rd_access;
    logic addr_ok;
    logic hit;
    logic soft_set;
    logic start_break;
    logic end_break;

    // Known offset decode
    function automatic logic abu_mapped(input logic [7:0] a);
        abu_mapped = (a == abu_pkg::OFF_STATUS_CONTROL) ||
                     (a == abu_pkg::OFF_ADDRESS_HIGH) ||
                     (a == abu_pkg::OFF_ADDRESS_LOW) ||
                     (a == abu_pkg::OFF_IRQ_STATUS) ||
                     (a == abu_pkg::OFF_IRQ_ENABLE) ||
                     (a == abu_pkg::OFF_IRQ_CLEAR);
    endfunction : abu_mapped

    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign addr_ok   = abu_mapped(paddr);
    assign soft_set  = wr_access && (paddr == abu_pkg::OFF_STATUS_CONTROL)
                       && pwdata[abu_pkg::BIT_ACTIVE];

    assign hit = break_enable_bit && cpu_address_valid && !stop_mode &&
                 (cpu_address == {break_address_high, break_address_low});

    // last-cycle match starts now
    // A remembered match is dropped once breaks are disabled
    assign start_break = (state == ABU_IDLE) && !stop_mode &&
                         ((hit && cpu_last_cycle) ||
                          (pending && break_enable_bit && cpu_last_cycle)
                          || soft_set);
    assign end_break = (state == ABU_BREAK) && cpu_return_from_interrupt;

    // ************************************************************
    // Test voltage synchroniser
    // ************************************************************
    // Three stages; level changes when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_sync  <= 3'h0;
            hv_level <= 1'b0;
        end else begin
            hv_sync <= {hv_sync[1:0], test_high_voltage_pin};
            if (hv_sync[1] == hv_sync[2]) begin
                hv_level <= hv_sync[2];
            end
        end
    end

    // ************************************************************
    // Control and status register
    // ************************************************************
    // enable bit at bit seven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_enable_bit <= 1'b0;
        end else if (wr_access && paddr == abu_pkg::OFF_STATUS_CONTROL) begin
            break_enable_bit <= pwdata[abu_pkg::BIT_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_active_flag <= 1'b0;
        end else if (hit || soft_set) begin
            break_active_flag <= 1'b1;
        end else if (wr_access && paddr == abu_pkg::OFF_STATUS_CONTROL) begin
            break_active_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_address_high <= abu_pkg::RST_BYTE;
            break_address_low  <= abu_pkg::RST_BYTE;
        end else if (wr_access) begin
            if (paddr == abu_pkg::OFF_ADDRESS_HIGH) begin
                break_address_high <= pwdata[7:0];
            end
            if (paddr == abu_pkg::OFF_ADDRESS_LOW) begin
                break_address_low <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Break sequencer
    // ************************************************************
    // Match mid-instruction waits for the instruction boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
        end else if (start_break || state == ABU_BREAK) begin
            pending <= 1'b0;
        end else if (!break_enable_bit) begin
            pending <= 1'b0;
        end else if (hit) begin
            pending <= 1'b1;
        end
    end

    // Break state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ABU_IDLE;
        end else begin
            unique case (state)
                ABU_IDLE: begin
                    if (start_break) begin
                        state <= ABU_BREAK;
                    end
                end
                ABU_BREAK: begin
                    if (end_break) begin
                        state <= ABU_IDLE;
                    end
                end
                default: state <= ABU_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_request             <= 1'b0;
            break_state               <= 1'b0;
            break_vector              <= abu_pkg::VEC_USER;
            software_interrupt_opcode <= abu_pkg::SOFT_INT_OPCODE;
            timer_halt                <= 1'b0;
            watchdog_disable          <= 1'b0;
        end else begin
            break_request    <= start_break;
            break_state      <= (state == ABU_BREAK) ? !end_break : start_break;
            break_vector     <= monitor_mode ? abu_pkg::VEC_MONITOR
                                             : abu_pkg::VEC_USER;
            software_interrupt_opcode <= abu_pkg::SOFT_INT_OPCODE;
            timer_halt       <= (state == ABU_BREAK) ? !end_break : start_break;
            watchdog_disable <= hv_level &&
                                ((state == ABU_BREAK) ? !end_break : start_break);
        end
    end

    // ************************************************************
    // Interrupt status, enable and clear
    // ************************************************************
    // Sticky events; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 3'h0;
            irq_enable <= 3'h0;
            irq        <= 1'b0;
        end else begin
            if (wr_access && paddr == abu_pkg::OFF_IRQ_ENABLE) begin
                irq_enable <= pwdata[2:0];
            end
            irq_status <= (irq_status &
                           ~((wr_access && paddr == abu_pkg::OFF_IRQ_CLEAR)
                             ? pwdata[2:0] : 3'h0))
                          | {end_break, soft_set && start_break,
                             hit && start_break && !soft_set};
            irq <= |(irq_status & irq_enable);
        end
    end

    // ************************************************************
    // APB slave: zero wait states
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !abu_mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    abu_pkg::OFF_STATUS_CONTROL:
                        prdata[7:0] <= {break_enable_bit, break_active_flag,
                                        6'h00};
                    abu_pkg::OFF_ADDRESS_HIGH: prdata[7:0] <= break_address_high;
                    abu_pkg::OFF_ADDRESS_LOW:  prdata[7:0] <= break_address_low;
                    abu_pkg::OFF_IRQ_STATUS:   prdata[2:0] <= irq_status;
                    abu_pkg::OFF_IRQ_ENABLE:   prdata[2:0] <= irq_enable;
                    default:                   prdata      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_req_vector: assert property (@(posedge pclk) disable iff (!presetn)
        break_request |-> break_vector ==
            ($past(monitor_mode) ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_USER))
        else $error("wrong break vector");
    a_last_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        (hit && cpu_last_cycle && state == ABU_IDLE && !stop_mode)
        |=> break_request)
        else $error("last-cycle match did not break");
    a_soft_break: assert property (@(posedge pclk) disable iff (!presetn)
        (soft_set && state == ABU_IDLE && !stop_mode) |=> break_request)
        else $error("software write did not break");
    a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        hit |=> break_active_flag)
        else $error("active flag not set by match");
    a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!break_enable_bit && !soft_set) |=> !break_request)
        else $error("break while disabled");
    a_rti_end: assert property (@(posedge pclk) disable iff (!presetn)
        end_break |=> (!break_state && state == ABU_IDLE))
        else $error("return did not end break");
    a_break_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        break_request |=> !break_request)
        else $error("break request longer than one cycle");
    a_state_rise: assert property (@(posedge pclk) disable iff (!presetn)
        break_request |-> break_state)
        else $error("break state not raised with request");
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == abu_pkg::OFF_STATUS_CONTROL &&
         !pwdata[abu_pkg::BIT_ACTIVE] && !hit) |=> !break_active_flag)
        else $error("active flag not cleared by write");
    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == abu_pkg::OFF_STATUS_CONTROL) |=>
        (break_enable_bit == $past(pwdata[abu_pkg::BIT_ENABLE])))
        else $error("enable bit not written");
    a_pending_drop: assert property (@(posedge pclk) disable iff (!presetn)
        !break_enable_bit |=> !pending)
        else $error("pending match kept while disabled");
    a_monitor_vec: assert property (@(posedge pclk) disable iff (!presetn)
        (break_state && $past(monitor_mode)) |->
        (break_vector == abu_pkg::VEC_MONITOR))
        else $error("monitor vector not used");
    a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready longer than one cycle");
    a_timer_halt: assert property (@(posedge pclk) disable iff (!presetn)
        timer_halt == break_state)
        else $error("timer halt not tied to break");
    a_wdog_off: assert property (@(posedge pclk) disable iff (!presetn)
        watchdog_disable |-> break_state)
        else $error("watchdog off outside break");
    a_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_mode && !soft_set) |=> !break_request)
        else $error("break in stop mode");
    c_match_break: cover property (@(posedge pclk) disable iff (!presetn)
        hit ##[1:20] break_request);
    c_soft_break: cover property (@(posedge pclk) disable iff (!presetn)
        soft_set ##1 break_request);
    c_full_cycle: cover property (@(posedge pclk) disable iff (!presetn)
        break_request ##[1:50] !break_state);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
    c_pending: cover property (@(posedge pclk) disable iff (!presetn)
        pending ##1 break_request);

endmodule : abu_top

`default_nettype wire

// file: bench/abu_cpu_model.sv
// CPU core model: steps program addresses and returns from breaks
`timescale 1ns/1ps
`default_nettype none
module abu_cpu_model #(
    parameter int RTI_DELAY = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        break_request,
    output logic      [15:0] cpu_address,
    output logic             cpu_address_valid,
    output logic             cpu_last_cycle,
    output logic             cpu_return_from_interrupt
);
    logic [15:0] pc;
    logic        phase;
    logic        in_break;
    logic [4:0]  wait_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= 16'h0100;
            phase <= 1'b0;
            in_break <= 1'b0;
            wait_cnt <= 5'h00;
            cpu_return_from_interrupt <= 1'b0;
        end else begin
            cpu_return_from_interrupt <= 1'b0;
            if (break_request) begin
                in_break <= 1'b1;
                wait_cnt <= 5'h00;
            end else if (in_break) begin
                wait_cnt <= wait_cnt + 5'h01;
                if (wait_cnt == 5'(RTI_DELAY)) begin
                    in_break <= 1'b0;
                    cpu_return_from_interrupt <= 1'b1;
                end
            end else if (run) begin
                phase <= ~phase;
                if (phase) pc <= pc + 16'h0001;
            end
        end
    end

    // Address bus shows inverted pc while not fetching
    assign cpu_address_valid = run && !in_break;
    assign cpu_last_cycle = cpu_address_valid && phase;
    assign cpu_address = cpu_address_valid ? pc : ~pc;
endmodule : abu_cpu_model
`default_nettype wire

// file: bench/address_breakpoint_unit_tb.sv
// Testbench for the address breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module address_breakpoint_unit_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        monitor_mode = 1'b0;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        test_high_voltage_pin = 1'b0;
    logic        cpu_run = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, brk_req, break_state, timer_halt;
    logic        watchdog_disable, irq, cpu_valid, cpu_last, cpu_rti;
    logic [15:0] break_vector, cpu_address;
    logic [7:0]  opcode;
    int          err_total = 0;
    int          total_checks = 0;
    int          brk_seen = 0;
    int          rti_seen = 0;

    always #4 pclk = ~pclk;

    abu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_address(cpu_address), .cpu_address_valid(cpu_valid),
        .cpu_last_cycle(cpu_last), .cpu_return_from_interrupt(cpu_rti),
        .monitor_mode(monitor_mode), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .test_high_voltage_pin(test_high_voltage_pin),
        .break_request(brk_req), .break_state(break_state),
        .break_vector(break_vector), .software_interrupt_opcode(opcode),
        .timer_halt(timer_halt), .watchdog_disable(watchdog_disable),
        .irq(irq));

    abu_cpu_model #(.RTI_DELAY(12)) cpu (.pclk(pclk), .presetn(presetn),
        .run(cpu_run), .break_request(brk_req), .cpu_address(cpu_address),
        .cpu_address_valid(cpu_valid), .cpu_last_cycle(cpu_last),
        .cpu_return_from_interrupt(cpu_rti));

    // Counts break requests and returns at each edge
    always @(posedge pclk) begin
        if (brk_req === 1'b1) brk_seen++;
        if (cpu_rti === 1'b1) rti_seen++;
    end

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", 32'(pready), 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rd_chk(input string what, input logic [7:0] a,
                input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(what, q, exp);
        check(what, 32'(e), 32'(exp_err));
    endtask : rd_chk

    // Waits a bounded time for a break request or a return
    task wait_on(input logic want_rti, input int c0);
        int n;
        n = 0;
        while ((want_rti ? rti_seen : brk_seen) == c0 && n < 80) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_on

    task reset_values;
        rd_chk("status rst", abu_pkg::OFF_STATUS_CONTROL, 32'h0, 1'b0);
        rd_chk("high rst", abu_pkg::OFF_ADDRESS_HIGH, 32'h0, 1'b0);
        rd_chk("low rst", abu_pkg::OFF_ADDRESS_LOW, 32'h0, 1'b0);
        rd_chk("unmapped", 8'h40, 32'h0, 1'b1);
        rd_chk("clear reg", abu_pkg::OFF_IRQ_CLEAR, 32'h0, 1'b0);
        check("vector rst", 32'(break_vector), 32'(abu_pkg::VEC_USER));
        check("opcode", 32'(opcode), 32'(abu_pkg::SOFT_INT_OPCODE));
        $display("Test reset values done");
    endtask : reset_values

    task run_break(input logic mon);
        logic [15:0] bp;
        int          c0;
        monitor_mode <= mon;
        wait_mode <= mon;
        test_high_voltage_pin <= mon;
        bp = cpu_address + 16'h0010;
        c0 = brk_seen;
        wr(abu_pkg::OFF_IRQ_ENABLE, 32'h1);
        wr(abu_pkg::OFF_ADDRESS_HIGH, {24'h0, bp[15:8]});
        wr(abu_pkg::OFF_ADDRESS_LOW, {24'h0, bp[7:0]});
        wr(abu_pkg::OFF_STATUS_CONTROL, 32'h80);
        wait_on(1'b0, c0);
        @(posedge pclk);
        check("break", 32'(brk_seen - c0), 32'h1);
        check("state", 32'(break_state), 32'h1);
        check("halt", 32'(timer_halt), 32'h1);
        check("vector", 32'(break_vector), mon ? 32'(abu_pkg::VEC_MONITOR)
                                          : 32'(abu_pkg::VEC_USER));
        check("watchdog", 32'(watchdog_disable), 32'(mon));
        rd_chk("status", abu_pkg::OFF_STATUS_CONTROL, 32'hC0, 1'b0);
        rd_chk("irq status", abu_pkg::OFF_IRQ_STATUS, 32'h1, 1'b0);
        check("irq", 32'(irq), 32'h1);
        c0 = rti_seen;
        wait_on(1'b1, c0);
        @(posedge pclk);
        check("state end", 32'(break_state), 32'h0);
        check("halt end", 32'(timer_halt), 32'h0);
        rd_chk("irq end", abu_pkg::OFF_IRQ_STATUS, 32'h5, 1'b0);
        wr(abu_pkg::OFF_STATUS_CONTROL, 32'h0);
        wr(abu_pkg::OFF_IRQ_CLEAR, 32'h7);
        rd_chk("flag clr", abu_pkg::OFF_STATUS_CONTROL, 32'h0, 1'b0);
        check("irq clr", 32'(irq), 32'h0);
        $display("Test match break mode %0d done", mon);
    endtask : run_break

    task soft_break;
        int c0;
        monitor_mode <= 1'b0;
        wait_mode <= 1'b0;
        c0 = brk_seen;
        wr(abu_pkg::OFF_STATUS_CONTROL, 32'h40);
        wait_on(1'b0, c0);
        @(posedge pclk);
        check("soft", 32'(brk_seen - c0), 32'h1);
        rd_chk("soft flag", abu_pkg::OFF_STATUS_CONTROL, 32'h40, 1'b0);
        rd_chk("soft irq", abu_pkg::OFF_IRQ_STATUS, 32'h2, 1'b0);
        check("irq masked", 32'(irq), 32'h0);
        c0 = rti_seen;
        wait_on(1'b1, c0);
        wr(abu_pkg::OFF_STATUS_CONTROL, 32'h0);
        wr(abu_pkg::OFF_IRQ_CLEAR, 32'h7);
        rd_chk("soft clr", abu_pkg::OFF_STATUS_CONTROL, 32'h0, 1'b0);
        $display("Test software break done");
    endtask : soft_break

    task no_break(input logic stop);
        logic [15:0] bp;
        int          c0;
        stop_mode <= stop;
        bp = cpu_address + 16'h0010;
        wr(abu_pkg::OFF_ADDRESS_HIGH, {24'h0, bp[15:8]});
        wr(abu_pkg::OFF_ADDRESS_LOW, {24'h0, bp[7:0]});
        wr(abu_pkg::OFF_STATUS_CONTROL, {24'h0, stop, 7'h0});
        c0 = brk_seen;
        repeat (60) @(posedge pclk);
        check("no break", 32'(brk_seen - c0), 32'h0);
        stop_mode <= 1'b0;
        rd_chk("kept hi", abu_pkg::OFF_ADDRESS_HIGH, 32'(bp[15:8]), 1'b0);
        rd_chk("kept lo", abu_pkg::OFF_ADDRESS_LOW, 32'(bp[7:0]), 1'b0);
        rd_chk("kept st", abu_pkg::OFF_STATUS_CONTROL, {24'h0, stop, 7'h0},
               1'b0);
        wr(abu_pkg::OFF_STATUS_CONTROL, 32'h0);
        $display("Test no break stop %0d done", stop);
    endtask : no_break

    task give_verdict;
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        cpu_run <= 1'b1;
        @(posedge pclk);
        reset_values;
        run_break(1'b0);
        run_break(1'b1);
        soft_break;
        no_break(1'b0);
        no_break(1'b1);
        give_verdict;
    end

    // Watchdog against a hang
    initial begin
        #200000;
        err_total++;
        give_verdict;
    end
endmodule : address_breakpoint_unit_tb
`default_nettype wire
